// ==== rtl/hcs_pkg.sv ====
// Constants for the harvester configuration select block.
// Assumes one 40 MHz core clock and an I2C target on the same die.
// Function
// - Answer I2C at seven-bit address 0x41
// - After I2C configuration, ignore every strap pin
// - Unwritten registers take defaults, not straps
// - Charge inhibit strap high blocks charging
// - Keep-alive strap high powers core from battery
// - Thermal guard blocks charging outside window
// - Host programs hot and cold limits
// - Thermal guard on unless strap tied high
// - Writing 1 to 0x0B applies staged registers
// - Start up from strap pins
// - Code 0x23 then load gives 0.285 V
// - No charging until cold start is done
package hcs_pkg;

  // Bus address of the target
  localparam logic [6:0] I2C_ADDR   = 7'h41;

  // Register offsets
  localparam logic [7:0] OFS_VER    = 8'h00;
  localparam logic [7:0] OFS_SRC    = 8'h01;
  localparam logic [7:0] OFS_OVDIS  = 8'h02;
  localparam logic [7:0] OFS_OVCH   = 8'h03;
  localparam logic [7:0] OFS_COLD   = 8'h04;
  localparam logic [7:0] OFS_HOT    = 8'h05;
  localparam logic [7:0] OFS_PWR    = 8'h06;
  localparam logic [7:0] OFS_LOAD   = 8'h0b;
  localparam logic [7:0] OFS_STAT   = 8'h0d;
  localparam logic [7:0] OFS_TEMP   = 8'h11;

  // Reset values of the staged registers
  localparam logic [6:0] SRC_RST    = 7'h77;
  localparam logic [5:0] OVDIS_RST  = 6'h2d;
  localparam logic [5:0] OVCH_RST   = 6'h33;
  localparam logic [7:0] COLD_RST   = 8'h8f;
  localparam logic [7:0] HOT_RST    = 8'h2f;
  localparam logic [3:0] PWR_RST    = 4'h7;

  // Power register field positions
  localparam int PWR_KA    = 0;  // Keep-alive enable
  localparam int PWR_HP    = 1;  // High-power mode enable
  localparam int PWR_TMON  = 2;  // Thermal guard enable
  localparam int PWR_CHDIS = 3;  // Charging disable

  // Control and status field positions
  localparam int LOAD_GO     = 0;  // Load staged configuration
  localparam int LOAD_BUSY   = 2;  // Load in progress
  localparam int STAT_TEMP   = 4;  // Temperature out of window
  localparam int STAT_CHARGE = 6;  // Charging active

  // Source regulation code for 0.285 V
  localparam logic [6:0] SRC_CODE_285MV = 7'h23;

  // Bits per byte on the bus
  localparam logic [3:0] BYTE_BITS = 4'h8;

endpackage

// ==== rtl/hcs_i2c_line.sv ====
// Line conditioner for the I2C clock and data pins.
// Assumes raw pin levels asynchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module hcs_i2c_line (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      sda_s,
  output logic      start_p,
  output logic      stop_p
);

  logic [2:0] scl_q;  // Two sync stages plus edge history
  logic [2:0] sda_q;  // Two sync stages plus edge history

  // Synchronise both pins; stage 0 feeds only stage 1
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], scl_i};
      sda_q <= {sda_q[1:0], sda_i};
    end
  end

  // Edges and bus conditions from stages 1 and 2 only
  assign scl_rise = scl_q[1] & ~scl_q[2];
  assign scl_fall = ~scl_q[1] & scl_q[2];
  assign sda_s    = sda_q[1];
  assign start_p  = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  assign stop_p   = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

endmodule
`default_nettype wire

// ==== rtl/hcs_config_select.sv ====
// Configuration select: I2C target, staged and active registers,
// strap capture and charge gating.
// Assumes temp_code and cold_start_done come from core_clk logic.
`timescale 1ns/1ps
`default_nettype none
module hcs_config_select #(
  parameter logic [7:0] VERSION = 8'h5a  // Arbitrary version value
) (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic       charge_inhibit_strap,
  input  wire logic       keep_alive_strap,
  input  wire logic       thermal_guard_strap,
  input  wire logic [5:0] source_level_straps,
  input  wire logic [2:0] battery_threshold_straps,
  input  wire logic       cold_start_done,
  input  wire logic [7:0] temp_code,
  output logic            charge_enable,
  output logic            keep_alive_en,
  output logic            thermal_guard_en,
  output logic            high_power_en,
  output logic            regulate_enable,
  output logic            temp_out_of_range,
  output logic            cfg_from_straps,
  output logic [6:0]      src_reg_code,
  output logic [2:0]      batt_strap_code,
  output logic [5:0]      ovdis_code,
  output logic [5:0]      ovch_code
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
  } hcs_state_e;

  // Bus conditioning outputs
  logic       scl_rise;
  logic       scl_fall;
  logic       sda_s;
  logic       start_p;
  logic       stop_p;

  // Target engine state
  hcs_state_e st_q;
  logic [3:0] cnt_q;      // Bits seen in the current byte
  logic [7:0] sh_q;       // Shift register
  logic       rw_q;       // Read transfer
  logic       first_q;    // Next written byte is the pointer
  logic       ack_q;      // Controller acked the read byte
  logic [7:0] ptr_q;      // Register pointer
  logic       oe_q;       // Pull data line low

  // Staged (bus-written) configuration
  logic [6:0] stg_src_q;
  logic [5:0] stg_ovdis_q;
  logic [5:0] stg_ovch_q;
  logic [7:0] stg_cold_q;
  logic [7:0] stg_hot_q;
  logic [3:0] stg_pwr_q;
  logic [5:0] wr_seen_q;  // Which staged registers the host wrote

  // Active configuration applied by the load command
  logic [6:0] act_src_q;
  logic [5:0] act_ovdis_q;
  logic [5:0] act_ovch_q;
  logic [7:0] act_cold_q;
  logic [7:0] act_hot_q;
  logic [3:0] act_pwr_q;
  logic       i2c_mode_q;  // Straps no longer used
  logic       busy_q;      // Load in progress, one cycle

  // Strap synchronisers, two stages each
  logic [11:0] strap1_q;
  logic [11:0] strap2_q;

  // Write strobe and load decode
  logic       byte_done;
  logic       wr_en;
  logic [7:0] rd_byte;
  logic       load_p;
  logic       addr_hit;

  // Selected configuration, before the output flops
  logic       inh_sel;
  logic       ka_sel;
  logic       tmon_sel;
  logic       hp_sel;
  logic [7:0] cold_sel;
  logic [7:0] hot_sel;
  logic       out_d;
  logic       chg_d;

  hcs_i2c_line u_line (
    .core_clk (core_clk),
    .rstn     (rstn),
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .scl_rise (scl_rise),
    .scl_fall (scl_fall),
    .sda_s    (sda_s),
    .start_p  (start_p),
    .stop_p   (stop_p)
  );

  // Byte boundary and bus decode
  assign byte_done = scl_fall && (cnt_q == hcs_pkg::BYTE_BITS);
  assign addr_hit  = (sh_q[7:1] == hcs_pkg::I2C_ADDR);
  assign wr_en     = byte_done && (st_q == ST_WR) && !first_q;
  assign load_p    = wr_en && (ptr_q == hcs_pkg::OFS_LOAD)
                     && sh_q[hcs_pkg::LOAD_GO];

  // Read data multiplexer, unmapped offsets read zero
  assign rd_byte =
    (ptr_q == hcs_pkg::OFS_VER)   ? VERSION :
    (ptr_q == hcs_pkg::OFS_SRC)   ? {1'b0, stg_src_q} :
    (ptr_q == hcs_pkg::OFS_OVDIS) ? {2'h0, stg_ovdis_q} :
    (ptr_q == hcs_pkg::OFS_OVCH)  ? {2'h0, stg_ovch_q} :
    (ptr_q == hcs_pkg::OFS_COLD)  ? stg_cold_q :
    (ptr_q == hcs_pkg::OFS_HOT)   ? stg_hot_q :
    (ptr_q == hcs_pkg::OFS_PWR)   ? {4'h0, stg_pwr_q} :
    (ptr_q == hcs_pkg::OFS_LOAD)  ? {5'h00, busy_q, 2'h0} :
    (ptr_q == hcs_pkg::OFS_STAT)  ? {1'b0, charge_enable, 1'b0,
                                     temp_out_of_range, 4'h0} :
    (ptr_q == hcs_pkg::OFS_TEMP)  ? temp_code : 8'h00;

  // Open-drain data: only ever pulls low
  assign sda_o  = 1'b0;
  assign sda_oe = oe_q;

  // Target engine: sample on rising clock, drive on falling clock
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q    <= ST_IDLE;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      rw_q    <= 1'b0;
      first_q <= 1'b0;
      ack_q   <= 1'b0;
      ptr_q   <= 8'h00;
      oe_q    <= 1'b0;
    end else if (start_p) begin
      // Start or repeated start
      st_q    <= ST_ADDR;
      cnt_q   <= 4'h0;
      oe_q    <= 1'b0;
    end else if (stop_p) begin
      st_q    <= ST_IDLE;
      oe_q    <= 1'b0;
    end else begin
      case (st_q)
        ST_ADDR, ST_WR: begin
          if (scl_rise) begin
            sh_q  <= {sh_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_done && st_q == ST_ADDR) begin
            // Acknowledge only our own address
            st_q    <= addr_hit ? ST_ADDR_ACK : ST_IDLE;
            oe_q    <= addr_hit;
            rw_q    <= sh_q[0];
            first_q <= 1'b1;
          end else if (byte_done) begin
            // Pointer byte first, data bytes advance it
            st_q    <= ST_WR_ACK;
            oe_q    <= 1'b1;
            first_q <= 1'b0;
            ptr_q   <= first_q ? sh_q : ptr_q + 8'h01;
          end
        end
        ST_ADDR_ACK, ST_WR_ACK: begin
          if (scl_fall) begin
            cnt_q <= 4'h0;
            if (st_q == ST_ADDR_ACK && rw_q) begin
              st_q <= ST_RD;
              sh_q <= rd_byte;
              oe_q <= ~rd_byte[7];
            end else begin
              st_q <= ST_WR;
              oe_q <= 1'b0;
            end
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_done) begin
            // Release for the controller's acknowledge
            st_q  <= ST_RD_ACK;
            oe_q  <= 1'b0;
            ptr_q <= ptr_q + 8'h01;
          end else if (scl_fall) begin
            sh_q <= {sh_q[6:0], 1'b0};
            oe_q <= ~sh_q[6];
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            ack_q <= ~sda_s;
          end else if (scl_fall) begin
            // Not acked: stop sending until the next start
            cnt_q <= 4'h0;
            st_q  <= ack_q ? ST_RD : ST_IDLE;
            sh_q  <= rd_byte;
            oe_q  <= ack_q & ~rd_byte[7];
          end
        end
        default: begin
          st_q <= ST_IDLE;
          oe_q <= 1'b0;
        end
      endcase
    end
  end

  // Staged registers; unwritten ones keep their defaults
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stg_src_q   <= hcs_pkg::SRC_RST;
      stg_ovdis_q <= hcs_pkg::OVDIS_RST;
      stg_ovch_q  <= hcs_pkg::OVCH_RST;
      stg_cold_q  <= hcs_pkg::COLD_RST;
      stg_hot_q   <= hcs_pkg::HOT_RST;
      stg_pwr_q   <= hcs_pkg::PWR_RST;
      wr_seen_q   <= 6'h00;
    end else if (wr_en) begin
      // Host-programmable limits and settings
      if (ptr_q == hcs_pkg::OFS_SRC) begin
        stg_src_q    <= sh_q[6:0];
        wr_seen_q[0] <= 1'b1;
      end else if (ptr_q == hcs_pkg::OFS_OVDIS) begin
        stg_ovdis_q  <= sh_q[5:0];
        wr_seen_q[1] <= 1'b1;
      end else if (ptr_q == hcs_pkg::OFS_OVCH) begin
        stg_ovch_q   <= sh_q[5:0];
        wr_seen_q[2] <= 1'b1;
      end else if (ptr_q == hcs_pkg::OFS_COLD) begin
        stg_cold_q   <= sh_q;
        wr_seen_q[3] <= 1'b1;
      end else if (ptr_q == hcs_pkg::OFS_HOT) begin
        stg_hot_q    <= sh_q;
        wr_seen_q[4] <= 1'b1;
      end else if (ptr_q == hcs_pkg::OFS_PWR) begin
        stg_pwr_q    <= sh_q[3:0];
        wr_seen_q[5] <= 1'b1;
      end
    end
  end

  // Load command copies staged into active; straps then ignored
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      act_src_q   <= hcs_pkg::SRC_RST;
      act_ovdis_q <= hcs_pkg::OVDIS_RST;
      act_ovch_q  <= hcs_pkg::OVCH_RST;
      act_cold_q  <= hcs_pkg::COLD_RST;
      act_hot_q   <= hcs_pkg::HOT_RST;
      act_pwr_q   <= hcs_pkg::PWR_RST;
      i2c_mode_q  <= 1'b0;
      busy_q      <= 1'b0;
    end else begin
      busy_q <= load_p;
      if (load_p) begin
        act_src_q   <= stg_src_q;
        act_ovdis_q <= stg_ovdis_q;
        act_ovch_q  <= stg_ovch_q;
        act_cold_q  <= stg_cold_q;
        act_hot_q   <= stg_hot_q;
        act_pwr_q   <= stg_pwr_q;
        i2c_mode_q  <= 1'b1;
      end
    end
  end

  // Strap synchronisers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      strap1_q <= 12'h000;
      strap2_q <= 12'h000;
    end else begin
      strap1_q <= {charge_inhibit_strap, keep_alive_strap,
                   thermal_guard_strap, battery_threshold_straps,
                   source_level_straps};
      strap2_q <= strap1_q;
    end
  end

  // Configuration source: straps or fixed defaults until loaded, then registers
  assign inh_sel  = i2c_mode_q ? act_pwr_q[hcs_pkg::PWR_CHDIS]
                               : strap2_q[11];
  assign ka_sel   = i2c_mode_q ? act_pwr_q[hcs_pkg::PWR_KA]
                               : strap2_q[10];
  assign tmon_sel = i2c_mode_q ? act_pwr_q[hcs_pkg::PWR_TMON]
                               : ~strap2_q[9];
  assign hp_sel   = i2c_mode_q ? act_pwr_q[hcs_pkg::PWR_HP] : 1'b1;
  assign cold_sel = i2c_mode_q ? act_cold_q : hcs_pkg::COLD_RST;
  assign hot_sel  = i2c_mode_q ? act_hot_q : hcs_pkg::HOT_RST;

  // Higher code is colder: window is hot_sel..cold_sel
  assign out_d = (temp_code > cold_sel) || (temp_code < hot_sel);
  assign chg_d = cold_start_done && !inh_sel
                 && !(tmon_sel && out_d);

  // Output flops
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      charge_enable     <= 1'b0;
      keep_alive_en     <= 1'b0;
      thermal_guard_en  <= 1'b0;
      high_power_en     <= 1'b0;
      regulate_enable   <= 1'b0;
      temp_out_of_range <= 1'b0;
      cfg_from_straps   <= 1'b1;
      src_reg_code      <= 7'h00;
      batt_strap_code   <= 3'h0;
      ovdis_code        <= 6'h00;
      ovch_code         <= 6'h00;
    end else begin
      charge_enable     <= chg_d;
      keep_alive_en     <= ka_sel;
      thermal_guard_en  <= tmon_sel;
      high_power_en     <= hp_sel;
      regulate_enable   <= cold_start_done;
      temp_out_of_range <= out_d;
      cfg_from_straps   <= ~i2c_mode_q;
      src_reg_code      <= i2c_mode_q ? act_src_q
                                      : {1'b0, strap2_q[5:0]};
      // Battery code frozen once the straps are ignored
      batt_strap_code   <= i2c_mode_q ? batt_strap_code
                                      : strap2_q[8:6];
      ovdis_code        <= act_ovdis_q;
      ovch_code         <= act_ovch_q;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Foreign address is never acknowledged
  AST_ADDR_NACK: assert property (
    (st_q == ST_ADDR && byte_done && sh_q[7:1] != hcs_pkg::I2C_ADDR)
      |=> (st_q == ST_IDLE && !sda_oe))
    else $error("foreign address acknowledged");

  AST_STRAPS_IGNORED: assert property (
    i2c_mode_q |=> (src_reg_code == $past(act_src_q)
                    && !cfg_from_straps))
    else $error("strap used after load");

  // Source, OVDIS and OVCH registers the host left alone load their defaults
  AST_DEFAULTS: assert property (
    load_p |=> ((wr_seen_q[0] || act_src_q == hcs_pkg::SRC_RST)
                && (wr_seen_q[1] || act_ovdis_q == hcs_pkg::OVDIS_RST)
                && (wr_seen_q[2] || act_ovch_q == hcs_pkg::OVCH_RST)))
    else $error("unwritten register not at default");

  AST_INHIBIT: assert property (
    (!i2c_mode_q && strap2_q[11]) |=> !charge_enable)
    else $error("charging despite inhibit strap");

  AST_KEEPALIVE: assert property (
    !i2c_mode_q |=> keep_alive_en == $past(strap2_q[10]))
    else $error("keep-alive not following strap");

  AST_THERMAL: assert property (
    (tmon_sel && out_d) |=> !charge_enable)
    else $error("charging outside thermal window");

  AST_HOT_PROG: assert property (
    (wr_en && ptr_q == 8'h05) |=> stg_hot_q == $past(sh_q))
    else $error("hot limit not stored");

  AST_TMON_DEFAULT: assert property (
    (!i2c_mode_q && !strap2_q[9]) |=> thermal_guard_en)
    else $error("thermal guard off by default");

  sequence s_load;
    load_p ##1 busy_q;
  endsequence

  AST_LOAD: assert property (
    load_p |-> s_load ##1 (act_pwr_q == $past(stg_pwr_q, 2)))
    else $error("load did not apply staged values");

  AST_MODE_CAUSE: assert property (
    $rose(i2c_mode_q) |-> $past(load_p))
    else $error("register mode without load");

  AST_CODE_285: assert property (
    (load_p && stg_src_q == hcs_pkg::SRC_CODE_285MV)
      |=> ##1 src_reg_code == hcs_pkg::SRC_CODE_285MV)
    else $error("0.285 V code not applied");

  AST_COLD_START: assert property (
    !cold_start_done |=> (!charge_enable && !regulate_enable))
    else $error("charging before cold start");

endmodule
`default_nettype wire

// ==== bench/hcs_host_model.sv ====
// I2C host model that reaches the configuration select registers.
// Assumes the bench resolves SDA with a pull-up and feeds it back.
`timescale 1ns/1ps
`default_nettype none
module hcs_host_model (
  input  wire logic core_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  // Bus idle: both lines released to the pull-ups
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // One SCL phase of ten core cycles, moved just past an edge
  task automatic ph();
    repeat (10) @(posedge core_clk);
    #1;
  endtask

  // Start from idle, or repeated start from SCL low
  task automatic start();
    sda_pull = 1'b0;
    ph();
    scl = 1'b1;
    ph();
    sda_pull = 1'b1;
    ph();
    scl = 1'b0;
  endtask

  // Stop: SDA rises while SCL is high
  task automatic stop();
    sda_pull = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    sda_pull = 1'b0;
    ph();
  endtask

  // One bit: data set while SCL low, line sampled at end of high
  task automatic xfer(input logic b, output logic r);
    sda_pull = ~b;
    ph();
    scl = 1'b1;
    ph();
    r   = sda;
    scl = 1'b0;
  endtask

  // Byte out, MSB first, then the target's acknowledge
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(d[i], r);
    end
    xfer(1'b1, r);
    ack = ~r;
  endtask

  // Byte in, MSB first; last byte is refused with a NACK
  task automatic rx(output logic [7:0] d, input logic last);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(1'b1, d[i]);
    end
    xfer(last, r);
  endtask

  // Pointer then one data byte; ok when all three bytes were acked
  task automatic write_reg(input logic [6:0] a, input logic [7:0] ofs,
                           input logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    start();
    tx({a, 1'b0}, k0);
    tx(ofs, k1);
    tx(d, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask

  // Pointer write, repeated start, one byte read back
  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
    logic k;
    start();
    tx({hcs_pkg::I2C_ADDR, 1'b0}, k);
    tx(ofs, k);
    start();
    tx({hcs_pkg::I2C_ADDR, 1'b1}, k);
    rx(d, 1'b1);
    stop();
  endtask

  // Load command: a 1 in the update bit of the control register
  task automatic load(output logic ok);
    write_reg(hcs_pkg::I2C_ADDR, hcs_pkg::OFS_LOAD, 8'h01, ok);
  endtask
endmodule
`default_nettype wire

// ==== bench/harvester_config_select_tb.sv ====
// Self-checking bench for the configuration select block.
// Assumes the host model of its own file and the design's package.
`timescale 1ns/1ps
`default_nettype none
module harvester_config_select_tb;
  logic       core_clk, rstn, scl, sda_pull, sda_o, sda_oe;
  logic       charge_inhibit_strap, keep_alive_strap, thermal_guard_strap;
  logic [5:0] source_level_straps;
  logic [2:0] battery_threshold_straps, batt_strap_code;
  logic       cold_start_done, charge_enable, keep_alive_en;
  logic [7:0] temp_code, rd;
  logic       thermal_guard_en, high_power_en, regulate_enable, ok;
  logic       temp_out_of_range, cfg_from_straps;
  logic [6:0] src_reg_code;
  logic [5:0] ovdis_code, ovch_code;
  int         n_fail, n_compared;
  // SDA wired-and of host and target, pull-up when both release
  wire logic  sda = ~(sda_pull | (sda_oe & ~sda_o));

  hcs_config_select u_hcs_config_select (
    .core_clk(core_clk), .rstn(rstn), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe),
    .charge_inhibit_strap(charge_inhibit_strap),
    .keep_alive_strap(keep_alive_strap),
    .thermal_guard_strap(thermal_guard_strap),
    .source_level_straps(source_level_straps),
    .battery_threshold_straps(battery_threshold_straps),
    .cold_start_done(cold_start_done), .temp_code(temp_code),
    .charge_enable(charge_enable), .keep_alive_en(keep_alive_en),
    .thermal_guard_en(thermal_guard_en), .high_power_en(high_power_en),
    .regulate_enable(regulate_enable),
    .temp_out_of_range(temp_out_of_range),
    .cfg_from_straps(cfg_from_straps), .src_reg_code(src_reg_code),
    .batt_strap_code(batt_strap_code), .ovdis_code(ovdis_code),
    .ovch_code(ovch_code)
  );
  hcs_host_model u_hcs_host_model (
    .core_clk(core_clk), .sda(sda), .scl(scl), .sda_pull(sda_pull)
  );

  // 40 MHz core clock
  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;

  // Wait n edges, then step just past the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Compare with case equality and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Strap mode: inhibit, keep-alive, thermal window and cold start
  task automatic test_straps();
    chk(8'(cfg_from_straps), 8'h01);
    chk(8'(src_reg_code), 8'h15);
    chk(8'(batt_strap_code), 8'h05);
    chk(8'(charge_enable), 8'h01);
    chk(8'(keep_alive_en), 8'h00);
    chk(8'(thermal_guard_en), 8'h01);
    charge_inhibit_strap = 1'b1;
    keep_alive_strap     = 1'b1;
    cyc(8);
    chk(8'(charge_enable), 8'h00);
    chk(8'(keep_alive_en), 8'h01);
    charge_inhibit_strap = 1'b0;
    keep_alive_strap     = 1'b0;
    temp_code            = 8'h90;
    cyc(8);
    chk(8'(temp_out_of_range), 8'h01);
    chk(8'(charge_enable), 8'h00);
    temp_code = 8'h2e;
    cyc(8);
    chk(8'(charge_enable), 8'h00);
    thermal_guard_strap = 1'b1;
    cyc(8);
    chk(8'(thermal_guard_en), 8'h00);
    chk(8'(charge_enable), 8'h01);
    thermal_guard_strap = 1'b0;
    temp_code           = 8'h50;
    cold_start_done     = 1'b0;
    cyc(8);
    chk(8'(charge_enable), 8'h00);
    chk(8'(regulate_enable), 8'h00);
    cold_start_done = 1'b1;
    cyc(8);
    chk(8'(regulate_enable), 8'h01);
    chk(8'(charge_enable), 8'h01);
    $display("test_straps done");
  endtask

  // Foreign address is ignored, staged register keeps its default
  task automatic test_addr();
    u_hcs_host_model.write_reg(7'h40, hcs_pkg::OFS_SRC, 8'h11, ok);
    chk(8'(ok), 8'h00);
    u_hcs_host_model.read_reg(hcs_pkg::OFS_SRC, rd);
    chk(rd, 8'h77);
    $display("test_addr done");
  endtask

  // Source code 0x23 staged, loaded, then straps lose their say
  task automatic test_load();
    u_hcs_host_model.write_reg(hcs_pkg::I2C_ADDR, hcs_pkg::OFS_SRC,
                               8'h23, ok);
    chk(8'(ok), 8'h01);
    u_hcs_host_model.read_reg(hcs_pkg::OFS_SRC, rd);
    chk(rd, 8'h23);
    chk(8'(src_reg_code), 8'h15);
    charge_inhibit_strap = 1'b1;
    u_hcs_host_model.load(ok);
    cyc(4);
    chk(8'(cfg_from_straps), 8'h00);
    chk(8'(src_reg_code), 8'h23);
    chk(8'(ovdis_code), 8'h2d);
    chk(8'(ovch_code), 8'h33);
    chk(8'(keep_alive_en), 8'h01);
    chk(8'(high_power_en), 8'h01);
    chk(8'(charge_enable), 8'h01);
    source_level_straps      = 6'h3f;
    battery_threshold_straps = 3'h2;
    cyc(8);
    chk(8'(src_reg_code), 8'h23);
    chk(8'(batt_strap_code), 8'h05);
    u_hcs_host_model.read_reg(hcs_pkg::OFS_LOAD, rd);
    chk(rd, 8'h00);
    $display("test_load done");
  endtask

  // Host-set limits narrow the thermal window after a load
  task automatic test_limits();
    u_hcs_host_model.write_reg(hcs_pkg::I2C_ADDR, hcs_pkg::OFS_COLD,
                               8'h60, ok);
    u_hcs_host_model.write_reg(hcs_pkg::I2C_ADDR, hcs_pkg::OFS_HOT,
                               8'h40, ok);
    u_hcs_host_model.load(ok);
    temp_code = 8'h70;
    cyc(8);
    chk(8'(charge_enable), 8'h00);
    temp_code = 8'h3f;
    cyc(8);
    chk(8'(temp_out_of_range), 8'h01);
    temp_code = 8'h50;
    cyc(8);
    chk(8'(charge_enable), 8'h01);
    u_hcs_host_model.read_reg(hcs_pkg::OFS_STAT, rd);
    chk(rd, 8'h40);
    u_hcs_host_model.read_reg(hcs_pkg::OFS_TEMP, rd);
    chk(rd, 8'h50);
    $display("test_limits done");
  endtask

  // Mid-run reset: straps rule again, staged values back at default
  task automatic test_reset();
    rstn = 1'b0;
    cyc(2);
    rstn = 1'b1;
    cyc(8);
    chk(8'(cfg_from_straps), 8'h01);
    chk(8'(src_reg_code), 8'h3f);
    chk(8'(batt_strap_code), 8'h02);
    chk(8'(charge_enable), 8'h00);
    u_hcs_host_model.read_reg(hcs_pkg::OFS_COLD, rd);
    chk(rd, 8'h8f);
    $display("test_reset done");
  endtask

  // Counts, verdict and end of run
  task automatic final_report();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence: straps at time zero, reset 12 cycles, then tests
  initial begin
    n_fail                   = 0;
    n_compared               = 0;
    rstn                     = 1'b0;
    charge_inhibit_strap     = 1'b0;
    keep_alive_strap         = 1'b0;
    thermal_guard_strap      = 1'b0;
    source_level_straps      = 6'h15;
    battery_threshold_straps = 3'h5;
    cold_start_done          = 1'b1;
    temp_code                = 8'h50;
    cyc(12);
    rstn = 1'b1;
    cyc(8);
    test_straps();
    test_addr();
    test_load();
    test_limits();
    test_reset();
    final_report();
  end

  // Watchdog: tests need about 9000 cycles, give 20000
  initial begin
    #500_000;
    n_fail++;
    $display("ERROR %0t: watchdog expired", $time);
    final_report();
  end
endmodule
`default_nettype wire
